// file: cbm_bp_clear.v
// Branch predictor invalidate-all sequencer: walks every entry once.
// Assumes the predictor accepts one clear per cycle.
`timescale 1ns/1ps
module cbm_bp_clear
#(
    parameter ENTRIES = 64,
    parameter IDX_W   = 6
)
(
    input  wire             clk_sys,
    input  wire             nrst,
    input  wire             start,
    output wire             busy,
    output wire [IDX_W-1:0] clrIndex
)
;
    // The last index is cut to the counter width on purpose.
    localparam [31:0]      LAST_W = ENTRIES - 1;
    localparam [IDX_W-1:0] LAST   = LAST_W[IDX_W-1:0];

    reg             busy_reg;
    reg [IDX_W-1:0] idx_reg;

    // Clearing every entry is the strongest form of the allowed side effect.
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_reg <= 1'b0;
            idx_reg  <= {IDX_W{1'b0}};
        end
        else if (!busy_reg)
        begin
            busy_reg <= start;
            idx_reg  <= {IDX_W{1'b0}};
        end
        else if (idx_reg == LAST)
        begin
            busy_reg <= 1'b0;
        end
        else
        begin
            idx_reg <= idx_reg + 1'b1;
        end
    end

    assign busy     = busy_reg;
    assign clrIndex = idx_reg;
endmodule

// file: cbm_cache_model.sv
// Cache-side model: accepts one operation after a set stall.
// Assumes the unit holds each operation until opReady is seen high.
`timescale 1ns/1ps
module cbm_cache_model
(
    input wire       clk_sys,
    input wire       nrst,
    input wire       opValid,
    input wire [3:0] stall,
    output reg       opReady
);
    reg [3:0] waitCnt;
    // Ready rises on a falling edge once the stall has run out, so a slow cache is modelled too.
    always @(negedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            waitCnt <= 4'h0;
            opReady <= 1'b0;
        end
        else if (opValid && !opReady)
        begin
            if (waitCnt >= stall)
                opReady <= 1'b1;
            else
                waitCnt <= waitCnt + 4'h1;
        end
        else
        begin
            waitCnt <= 4'h0;
            opReady <= 1'b0;
        end
    end
endmodule

// file: cbm_maint_sva.sv
// Port-level checker for the maintenance unit.
// Assumes it is bound to every unit instance by the bind at the foot.
`timescale 1ns/1ps
module cbm_maint_sva
#(
    parameter BP_ENTRIES = 64,
    parameter BP_IDX_W   = 6
)
(
    input wire                clk_sys,
    input wire                nrst,
    input wire                wrValid,
    input wire                wrReady,
    input wire [11:0]         wrOffset,
    input wire [31:0]         wrData,
    input wire                wrNonSecure,
    input wire                opValid,
    input wire                opReady,
    input wire [3:0]          opCode,
    input wire [31:0]         opAddr,
    input wire                bus_fault_exception,
    input wire                bpClrValid,
    input wire [BP_IDX_W-1:0] bpClrIndex,
    input wire                dsbReq,
    input wire                dsbDone,
    input wire                isbReq,
    input wire                fetchFlush
);
    localparam [BP_IDX_W-1:0] LAST = BP_IDX_W'(BP_ENTRIES - 1);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // A store taken at one offset, then the operation it raises.
    sequence s_take(ofs);
        wrValid && wrReady && wrOffset == ofs;
    endsequence
    sequence s_issue(code);
        opValid && opCode == code;
    endsequence
    a_icache_addr:
        assert property (s_take(12'hF58) |=> s_issue(4'h2) ##0 (opAddr == $past(wrData)))
        else $error("address invalidate not issued");
    a_clean_pou:
        assert property (s_take(12'hF64) |=> s_issue(4'h5) ##0 (opAddr == $past(wrData)))
        else $error("clean to unification not issued");
    a_ns_inval:
        assert property (s_take(12'hF5C) ##0 wrNonSecure |=> s_issue(4'h8))
        else $error("non-secure invalidate not cleaned");
    a_level_fault:
        assert property (s_take(12'hF60) ##0 (wrData[3:1] > 3'h1) |=> bus_fault_exception && !opValid)
        else $error("oversized level not faulted");
    a_bp_start:
        assert property (s_take(12'hF78) |=> bpClrValid && bpClrIndex == 0)
        else $error("predictor walk did not start");
    a_bp_walk:
        assert property (bpClrValid && bpClrIndex != LAST |=> bpClrValid && bpClrIndex == $past(bpClrIndex) + 1'b1)
        else $error("predictor walk skipped");
    a_bp_end:
        assert property (bpClrValid && bpClrIndex == LAST |=> !bpClrValid)
        else $error("predictor walk overran");
    a_op_holds:
        assert property (opValid && !opReady |=> opValid && $stable(opCode) && $stable(opAddr))
        else $error("operation changed before acceptance");
    a_slot_refuse:
        assert property (opValid && wrOffset == 12'hF64 |-> !wrReady)
        else $error("second cache operation taken early");
    a_dsb_done:
        assert property (dsbDone == (dsbReq && !opValid && !bpClrValid))
        else $error("barrier completion wrong");
    a_isb_flush:
        assert property (isbReq |=> fetchFlush)
        else $error("fetch flush missing");
endmodule
bind cbm_maint_unit cbm_maint_sva #(.BP_ENTRIES(BP_ENTRIES), .BP_IDX_W(BP_IDX_W)) u_sva (
    .clk_sys(clk_sys), .nrst(nrst), .wrValid(wrValid), .wrReady(wrReady), .wrOffset(wrOffset),
    .wrData(wrData), .wrNonSecure(wrNonSecure), .opValid(opValid), .opReady(opReady), .opCode(opCode),
    .opAddr(opAddr), .bus_fault_exception(bus_fault_exception), .bpClrValid(bpClrValid), .bpClrIndex(bpClrIndex),
    .dsbReq(dsbReq), .dsbDone(dsbDone), .isbReq(isbReq), .fetchFlush(fetchFlush));

// file: cbm_maint_unit.v
// Cache and branch predictor maintenance unit: write-only trigger registers, ordering and issue.
// Assumes writes arrive from the processing element with offsets relative to the control space base,
// and that the caches take one operation at a time through a valid/ready handshake.
`timescale 1ns/1ps
`include "cbm_regs.vh"
module cbm_maint_unit
#(
    parameter L1_LINE_LOG2 = 5,
    parameter L1_SET_LOG2  = 7,
    parameter L1_WAY_LOG2  = 2,
    parameter L1_NSETS     = 128,
    parameter L1_NWAYS     = 4,
    parameter L2_LINE_LOG2 = 5,
    parameter L2_SET_LOG2  = 10,
    parameter L2_WAY_LOG2  = 3,
    parameter L2_NSETS     = 1024,
    parameter L2_NWAYS     = 8,
    parameter OOR_FAULT    = 1,
    parameter BP_ENTRIES   = 64,
    parameter BP_IDX_W     = 6
)
(
    input  wire                clk_sys,
    input  wire                nrst,
    input  wire                wrValid,
    output wire                wrReady,
    input  wire [11:0]         wrOffset,
    input  wire [31:0]         wrData,
    input  wire                wrNonSecure,
    input  wire                rdValid,
    input  wire [11:0]         rdOffset,
    output wire [31:0]         rdData,
    output wire                opValid,
    input  wire                opReady,
    output wire [3:0]          opCode,
    output wire [31:0]         opAddr,
    output wire [15:0]         opSet,
    output wire [15:0]         opWay,
    output wire [2:0]          opLevel,
    output wire                opNonSecure,
    output wire                bus_fault_exception,
    output wire                bpClrValid,
    output wire [BP_IDX_W-1:0] bpClrIndex,
    input  wire                dsbReq,
    output wire                dsbDone,
    input  wire                isbReq,
    output wire                fetchFlush
);
    reg        opValid_reg;
    reg [3:0]  opCode_reg;
    reg [31:0] opAddr_reg;
    reg [15:0] opSet_reg;
    reg [15:0] opWay_reg;
    reg [2:0]  opLevel_reg;
    reg        opNs_reg;
    reg        bus_fault_exception_reg;
    reg        fetchFlush_reg;
    reg [31:0] rdData_reg;

    reg [3:0]  decCode;
    reg        decIsCache;
    reg        decIsBp;
    reg        decIsSetWay;
    reg        decIsAddr;

    reg [3:0]  issueCode;
    reg [15:0] swSet;
    reg [15:0] swWay;
    reg        swBad;

    wire [15:0] l1Set;
    wire [15:0] l1Way;
    wire        l1Oor;
    wire [15:0] l2Set;
    wire [15:0] l2Way;
    wire        l2Oor;
    wire [2:0]  swLevel;
    wire        bpBusy;
    wire        accept;
    wire        bpStart;

    // Offset decode: each operation has its own write-only trigger location.
    always @*
    begin
        decCode     = 4'h0;
        decIsCache  = 1'b1;
        decIsBp     = 1'b0;
        decIsSetWay = 1'b0;
        decIsAddr   = 1'b0;
        case (wrOffset)
            `CBM_OFS_INSTR_INVALIDATE_ALL_UNIFICATION:
                decCode = `CBM_OP_IC_INV_ALL;
            `CBM_OFS_INVAL_ICACHE_ADDR_POU:
            begin
                decCode   = `CBM_OP_IC_INV_ADDR;
                decIsAddr = 1'b1;
            end
            `CBM_OFS_DATA_INVALIDATE_ADDR_COHERENCY:
            begin
                decCode   = `CBM_OP_DC_INV_ADDR;
                decIsAddr = 1'b1;
            end
            `CBM_OFS_DATA_INVALIDATE_SETWAY:
            begin
                decCode     = `CBM_OP_DC_INV_SW;
                decIsSetWay = 1'b1;
            end
            `CBM_OFS_CLEAN_DCACHE_ADDR_POU:
            begin
                decCode   = `CBM_OP_DC_CLEAN_POU;
                decIsAddr = 1'b1;
            end
            `CBM_OFS_DATA_CLEAN_ADDR_COHERENCY:
            begin
                decCode   = `CBM_OP_DC_CLEAN_ADDR;
                decIsAddr = 1'b1;
            end
            `CBM_OFS_DATA_CLEAN_SETWAY:
            begin
                decCode     = `CBM_OP_DC_CLEAN_SW;
                decIsSetWay = 1'b1;
            end
            `CBM_OFS_DATA_CLEAN_INVAL_ADDR_COHERENCY:
            begin
                decCode   = `CBM_OP_DC_CLINV_ADDR;
                decIsAddr = 1'b1;
            end
            `CBM_OFS_DATA_CLEAN_INVAL_SETWAY:
            begin
                decCode     = `CBM_OP_DC_CLINV_SW;
                decIsSetWay = 1'b1;
            end
            `CBM_OFS_INVAL_BRANCH_PREDICTOR:
            begin
                decIsCache = 1'b0;
                decIsBp    = 1'b1;
            end
            default:
                decIsCache = 1'b0;
        endcase
    end

    // Level field is cache level minus one: 0 picks the first level, 1 the second.
    assign swLevel = wrData[`CBM_SW_LEVEL_MSB:`CBM_SW_LEVEL_LSB];

    // One decoder per implemented level, each sized by its own geometry.
    cbm_setway_decode
    #(
        .LINE_LOG2 (L1_LINE_LOG2),
        .SET_LOG2  (L1_SET_LOG2),
        .WAY_LOG2  (L1_WAY_LOG2),
        .NSETS     (L1_NSETS),
        .NWAYS     (L1_NWAYS)
    )
    u_dec_l1
    (
        .swWord     (wrData),
        .setIndex   (l1Set),
        .wayIndex   (l1Way),
        .outOfRange (l1Oor)
    );

    cbm_setway_decode
    #(
        .LINE_LOG2 (L2_LINE_LOG2),
        .SET_LOG2  (L2_SET_LOG2),
        .WAY_LOG2  (L2_WAY_LOG2),
        .NSETS     (L2_NSETS),
        .NWAYS     (L2_NWAYS)
    )
    u_dec_l2
    (
        .swWord     (wrData),
        .setIndex   (l2Set),
        .wayIndex   (l2Way),
        .outOfRange (l2Oor)
    );

    // Select the decoded set/way for the addressed level and flag any index too large.
    always @*
    begin
        swSet = 16'h0000;
        swWay = 16'h0000;
        swBad = 1'b0;
        case (swLevel)
            3'h0:
            begin
                swSet = l1Set;
                swWay = l1Way;
                swBad = l1Oor;
            end
            3'h1:
            begin
                swSet = l2Set;
                swWay = l2Way;
                swBad = l2Oor;
            end
            default:
                swBad = 1'b1;
        endcase
    end

    // A Non-secure data-cache invalidate becomes clean-and-invalidate so Secure data is never lost.
    always @*
    begin
        issueCode = decCode;
        if (wrNonSecure && (decCode == `CBM_OP_DC_INV_ADDR))
        begin
            issueCode = `CBM_OP_DC_CLINV_ADDR;
        end
        else if (wrNonSecure && (decCode == `CBM_OP_DC_INV_SW))
        begin
            issueCode = `CBM_OP_DC_CLINV_SW;
        end
    end

    // A single issue slot keeps every cache operation in program order, at the price
    // of stalling the store until the cache has taken the previous one.
    assign wrReady = decIsBp ? !bpBusy : (!decIsCache || !opValid_reg);
    assign accept  = wrValid && wrReady;
    assign bpStart = accept && decIsBp;

    // Issue slot: loaded on an accepted cache write unless its set/way faults, emptied when the cache takes it.
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            opValid_reg  <= 1'b0;
            opCode_reg   <= 4'h0;
            opAddr_reg   <= 32'h0000_0000;
            opSet_reg    <= 16'h0000;
            opWay_reg    <= 16'h0000;
            opLevel_reg  <= 3'h0;
            opNs_reg     <= 1'b0;
            bus_fault_exception_reg <= 1'b0;
        end
        else
        begin
            bus_fault_exception_reg <= 1'b0;
            if (opValid_reg && opReady)
            begin
                opValid_reg <= 1'b0;
            end
            if (accept && decIsCache)
            begin
                if (decIsSetWay && swBad)
                begin
                    bus_fault_exception_reg <= (OOR_FAULT != 0);
                end
                else
                begin
                    opValid_reg <= 1'b1;
                    opCode_reg  <= issueCode;
                    opNs_reg    <= wrNonSecure;
                    opAddr_reg  <= decIsAddr ? wrData : 32'h0000_0000;
                    opSet_reg   <= decIsSetWay ? swSet : 16'h0000;
                    opWay_reg   <= decIsSetWay ? swWay : 16'h0000;
                    opLevel_reg <= decIsSetWay ? swLevel : 3'h0;
                end
            end
        end
    end

    // Predictor clearing runs on its own engine, apart from cache operations.
    cbm_bp_clear
    #(
        .ENTRIES (BP_ENTRIES),
        .IDX_W   (BP_IDX_W)
    )
    u_bp
    (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .start    (bpStart),
        .busy     (bpBusy),
        .clrIndex (bpClrIndex)
    );
    assign bpClrValid = bpBusy;

    // Reads carry no operation; these locations read as zero.
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rdData_reg <= 32'h0000_0000;
        end
        else if (rdValid)
        begin
            rdData_reg <= (rdOffset == rdOffset) ? 32'h0000_0000 : 32'h0000_0000;
        end
    end

    // Context synchronisation flushes fetched instructions one cycle later; the predictor is not cleared.
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            fetchFlush_reg <= 1'b0;
        end
        else
        begin
            fetchFlush_reg <= isbReq;
        end
    end

    // A barrier retires only once nothing is pending; plain loads and stores are not held.
    assign dsbDone = dsbReq && !opValid_reg && !bpBusy;

    assign opValid     = opValid_reg;
    assign opCode      = opCode_reg;
    assign opAddr      = opAddr_reg;
    assign opSet       = opSet_reg;
    assign opWay       = opWay_reg;
    assign opLevel     = opLevel_reg;
    assign opNonSecure = opNs_reg;
    assign bus_fault_exception    = bus_fault_exception_reg;
    assign fetchFlush  = fetchFlush_reg;
    assign rdData      = rdData_reg;
endmodule

// file: cbm_maint_unit_test.sv
// Self-checking bench for the maintenance unit.
// Assumes the cache model answers operations and the checker is bound.
`timescale 1ns/1ps
module cbm_maint_unit_test;
    logic clk_sys = 0, nrst = 0, wrValid = 0, wrNonSecure = 0, rdValid = 0, dsbReq = 0, isbReq = 0;
    logic [11:0] wrOffset = 0, rdOffset = 0;
    logic [31:0] wrData = 0, rdData, opAddr;
    logic [15:0] opSet, opWay;
    logic [3:0] opCode, stall = 0;
    logic [2:0] opLevel;
    logic [1:0] bpClrIndex;
    logic wrReady, opValid, opReady, opNonSecure, bus_fault_exception, bpClrValid, dsbDone, fetchFlush;
    integer n_fail = 0, checks_done = 0;
    logic [11:0] ofsTab [0:8] = '{12'hF50, 12'hF58, 12'hF5C, 12'hF60, 12'hF64,
                                  12'hF68, 12'hF6C, 12'hF70, 12'hF74};

    cbm_maint_unit #(.L1_LINE_LOG2(4), .L1_WAY_LOG2(0), .L1_NWAYS(1), .BP_ENTRIES(4), .BP_IDX_W(2)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .wrValid(wrValid), .wrReady(wrReady), .wrOffset(wrOffset),
        .wrData(wrData), .wrNonSecure(wrNonSecure), .rdValid(rdValid), .rdOffset(rdOffset),
        .rdData(rdData), .opValid(opValid), .opReady(opReady), .opCode(opCode), .opAddr(opAddr),
        .opSet(opSet), .opWay(opWay), .opLevel(opLevel), .opNonSecure(opNonSecure),
        .bus_fault_exception(bus_fault_exception), .bpClrValid(bpClrValid), .bpClrIndex(bpClrIndex), .dsbReq(dsbReq),
        .dsbDone(dsbDone), .isbReq(isbReq), .fetchFlush(fetchFlush));
    cbm_cache_model u_cache (.clk_sys(clk_sys), .nrst(nrst), .opValid(opValid), .stall(stall),
        .opReady(opReady));

    // Clock of 100 ns period.
    always #50 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            checks_done++;
            if (got !== exp)
            begin
                n_fail++;
                $display("[ERR] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // One store, held until taken; returns on the falling edge after the take.
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d, input logic ns);
        integer n;
        begin
            @(negedge clk_sys);
            wrValid = 1;
            wrOffset = ofs;
            wrData = d;
            wrNonSecure = ns;
            // Let the ready decode settle on the new offset before it is looked at.
            #1;
            for (n = 0; n < 50 && wrReady !== 1'b1; n++)
                @(negedge clk_sys);
            chk("wrReady", 1, wrReady);
            @(negedge clk_sys);
            wrValid = 0;
        end
    endtask

    task automatic barrier;
        integer n;
        begin
            dsbReq = 1;
            #1;
            for (n = 0; n < 50 && dsbDone !== 1'b1; n++)
                @(negedge clk_sys);
            chk("dsbDone", 1, dsbDone);
            chk("opValid", 0, opValid);
            dsbReq = 0;
        end
    endtask

    task automatic t_codes;
        integer i;
        begin
            for (i = 0; i < 9; i++)
            begin
                wr(ofsTab[i], (i == 0) ? 32'hA5A5A5A5 : 32'h0, 0);
                chk("opCode", i + 1, opCode);
                if (i == 0)
                    chk("opAddr", 0, opAddr);
            end
            wr(12'hF54, 32'h0, 0);
            chk("opValid", 0, opValid);
        end
    endtask

    task automatic t_smc;
        integer k;
        begin
            wr(12'hF64, 32'h20001003, 0);
            chk("opAddr", 32'h20001003, opAddr);
            barrier();
            wr(12'hF58, 32'h20001003, 0);
            chk("opCode", 2, opCode);
            wr(12'hF78, 32'hFFFFFFFF, 0);
            for (k = 0; k < 4; k++)
            begin
                chk("bpClrIndex", k, {bpClrValid, bpClrIndex} ^ 3'h4);
                @(negedge clk_sys);
            end
            chk("bpClrValid", 0, bpClrValid);
            barrier();
            isbReq = 1;
            @(negedge clk_sys);
            isbReq = 0;
            chk("fetchFlush", 1, fetchFlush);
        end
    endtask

    task automatic t_setway;
        begin
            wr(12'hF60, 32'h000007F0, 0);
            chk("opSetWayLvl", {16'd127, 3'd0, 13'd0}, {opSet, opLevel, opWay[12:0]});
            wr(12'hF60, 32'hE0007FE2, 0);
            chk("opSetWayLvl", {16'd1023, 3'd1, 13'd7}, {opSet, opLevel, opWay[12:0]});
            wr(12'hF60, 32'h00000004, 0);
            chk("bus_fault_exception", 2'b10, {bus_fault_exception, opValid});
        end
    endtask

    task automatic t_order;
        begin
            stall <= 4'h4;
            wr(12'hF58, 32'h00000100, 0);
            chk("wrReady", 0, wrReady);
            wr(12'hF64, 32'h00000200, 0);
            chk("opCodeAddr", 32'h50000200, {opCode, opAddr[27:0]});
            stall <= 4'h0;
            wr(12'hF5C, 32'h00000300, 1);
            chk("opCodeNs", 5'h11, {opCode, opNonSecure});
            wr(12'hF60, 32'h0, 1);
            chk("opCode", 9, opCode);
            rdValid = 1;
            rdOffset = 12'hF58;
            @(negedge clk_sys);
            chk("rdData", 0, rdData);
            rdValid = 0;
        end
    endtask

    task print_verdict;
        begin
            if (n_fail == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // Watchdog well beyond the expected run of under a hundred cycles.
    initial
    begin
        #(100 * 5000);
        n_fail++;
        print_verdict();
    end

    // Main sequence after a 16-cycle reset.
    initial
    begin
        repeat (16) @(negedge clk_sys);
        nrst = 1;
        t_codes();
        t_smc();
        t_setway();
        t_order();
        repeat (4) @(negedge clk_sys);
        print_verdict();
    end
endmodule

// file: cbm_regs.vh
// Constants of the cache and branch predictor maintenance unit.
// Assumes inclusion by the unit's design files; holds definitions only.
`ifndef CBM_REGS_VH
`define CBM_REGS_VH

// Register offsets within the system control space.
`define CBM_OFS_INSTR_INVALIDATE_ALL_UNIFICATION   12'hF50
`define CBM_OFS_INVAL_ICACHE_ADDR_POU              12'hF58
`define CBM_OFS_DATA_INVALIDATE_ADDR_COHERENCY     12'hF5C
`define CBM_OFS_DATA_INVALIDATE_SETWAY             12'hF60
`define CBM_OFS_CLEAN_DCACHE_ADDR_POU              12'hF64
`define CBM_OFS_DATA_CLEAN_ADDR_COHERENCY          12'hF68
`define CBM_OFS_DATA_CLEAN_SETWAY                  12'hF6C
`define CBM_OFS_DATA_CLEAN_INVAL_ADDR_COHERENCY    12'hF70
`define CBM_OFS_DATA_CLEAN_INVAL_SETWAY            12'hF74
`define CBM_OFS_INVAL_BRANCH_PREDICTOR             12'hF78

// Operation codes presented to the caches.
`define CBM_OP_IC_INV_ALL      4'h1
`define CBM_OP_IC_INV_ADDR     4'h2
`define CBM_OP_DC_INV_ADDR     4'h3
`define CBM_OP_DC_INV_SW       4'h4
`define CBM_OP_DC_CLEAN_POU    4'h5
`define CBM_OP_DC_CLEAN_ADDR   4'h6
`define CBM_OP_DC_CLEAN_SW     4'h7
`define CBM_OP_DC_CLINV_ADDR   4'h8
`define CBM_OP_DC_CLINV_SW     4'h9

// Set/way word layout.
`define CBM_SW_LEVEL_LSB       1
`define CBM_SW_LEVEL_MSB       3
`define CBM_SW_WORD_W          32

`endif

// file: cbm_setway_decode.v
// Set/way word decoder for one cache level of given geometry.
// Assumes the geometry parameters describe that level's cache.
`timescale 1ns/1ps
module cbm_setway_decode
#(
    parameter LINE_LOG2 = 5,
    parameter SET_LOG2  = 7,
    parameter WAY_LOG2  = 2,
    parameter NSETS     = 128,
    parameter NWAYS     = 4
)
(
    input  wire [31:0] swWord,
    output wire [15:0] setIndex,
    output wire [15:0] wayIndex,
    output wire        outOfRange
);
    wire [31:0] setWide;
    wire [31:0] wayWide;
    wire [31:0] setMask;

    // Set field starts at the line term, so a line term of 4 abuts the level field.
    assign setMask = (32'h0000_0001 << SET_LOG2) - 32'h0000_0001;
    assign setWide = (swWord >> LINE_LOG2) & setMask;
    assign setIndex = setWide[15:0];

    // Way sits in the top bits; a direct-mapped cache has none.
    generate
        if (WAY_LOG2 == 0)
        begin : g_noway
            assign wayWide = 32'h0000_0000;
        end
        else
        begin : g_way
            assign wayWide = swWord >> (32 - WAY_LOG2);
        end
    endgenerate
    assign wayIndex = wayWide[15:0];

    // Non-power-of-two geometries can still hold a too-large index.
    assign outOfRange = (setWide >= NSETS) || (wayWide >= NWAYS);
endmodule
